// ---- logic/meter_ctl_pkg.sv ----
// Constants for the meter output control command interpreter
package meter_ctl_pkg;
  // Clock and timing
  localparam int CLK_HZ      = 50_000_000;
  localparam int T_SHORT_MS  = 2;   // Short turnaround window start
  localparam int T_LONG_MS   = 50;  // Long turnaround window start
  localparam int SHORT_CYC   = (T_SHORT_MS * CLK_HZ + 999) / 1000;
  localparam int LONG_CYC    = (T_LONG_MS * CLK_HZ + 999) / 1000;
  localparam int BAUD_RATE   = 9600;
  localparam int BAUD_CYC    = CLK_HZ / BAUD_RATE;
  localparam int FRAME_BITS  = 10;
  localparam int DATA_BITS   = 7;
  // Character codes
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_STAR   = 8'h2a;
  localparam logic [7:0] CH_DOT    = 8'h2e;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_WRITE  = 8'h56;
  localparam logic [7:0] CH_READ   = 8'h54;
  localparam logic [7:0] CH_RESET  = 8'h52;
  localparam logic [7:0] ID_CTRL   = 8'h4a;
  localparam logic [7:0] ID_LEVEL  = 8'h49;
  localparam logic [7:0] ID_LIM1   = 8'h45;
  localparam logic [7:0] ID_LIM4   = 8'h48;
  // Control/status field positions
  localparam int CS_LIM_LSB  = 0;
  localparam int CS_MANUAL   = 4;
  localparam int CS_SENSOR   = 6;
  // Analog level
  localparam int            LEVEL_W   = 12;
  localparam logic [15:0]   LEVEL_MAX = 16'h0fff;
  // Parity selection
  localparam logic [1:0] PAR_MARK = 2'h0;
  localparam logic [1:0] PAR_ODD  = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  // Reply lengths
  localparam logic [2:0] LEN_CTRL  = 3'h3;
  localparam logic [2:0] LEN_LEVEL = 3'h6;
  // Reset values
  localparam logic [3:0]         LIM_RST   = 4'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 12'h000;
endpackage

// ---- logic/meter_serial_output_control.sv ----
// Serial command interpreter for the meter setpoint and analog outputs
// What this block does
// (RL1) Control bits 0..3 show limit outputs one to four, 1 means on.
// (RL2) Bit 4 set selects manual: outputs follow written bits and level.
// (RL3) Control bits 5 and 7 always read zero.
// (RL4) Control bit 6 reports sensor failure, 1 means failed.
// (RL5) In automatic mode written setpoint bits can only turn outputs off.
// (RL6) Control value is one character; LF, CR, dollar, star, dot end early.
// (RL7) Host avoids writing control values equal to terminator codes.
// (RL8) Analog level holds 0..4095, linear to output full scale.
// (RL9) Level write applies at once in manual, stored only in automatic.
// (RL10) Half duplex: commands ignored while transmitting a reply.
// (RL11) Host waits for command processing before sending the next.
// (RL12) Star terminated reads reply 50 to 100 ms after terminator.
// (RL13) Dollar terminated reads reply 2 to 50 ms after terminator.
// (RL14) Host releases its drivers within 2 ms of a dollar terminator.
// (RL15) Replyless commands execute within 2..50 ms, then accept new ones.
// (RL16) After the last reply character the receiver is ready again.
// (RL17) Every character takes ten bit periods.
// (RL18) Frames start with a start bit, then data LSB first.
// (RL19) Received parity ignored; sent parity is odd, even or mark.
// (RL20) At least one stop bit; line idles high; any gap allowed.
// (RL21) Write is command letter, register letter, data, terminator.
// (RL22) Control read returns outputs, mode and sensor status.
`timescale 1ns/1ps
`default_nettype none
module meter_serial_output_control
  import meter_ctl_pkg::*;
#(
  parameter int BAUD_DIV   = BAUD_CYC,
  parameter int SHORT_WAIT = SHORT_CYC,
  parameter int LONG_WAIT  = LONG_CYC
) (
  // Clock, reset, enable
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic               ce,
  // Serial pins
  input  wire logic               rx_pin,
  output logic                    tx_pin,
  output logic                    tx_oe,
  // Configuration
  input  wire logic [1:0]         parity_sel,
  // Internal control sources
  input  wire logic [3:0]         limit_auto,
  input  wire logic [LEVEL_W-1:0] level_auto,
  input  wire logic               sensor_fail,
  // Outputs
  output logic                    first_limit_output,
  output logic                    second_limit_output,
  output logic                    third_limit_output,
  output logic                    fourth_limit_output,
  output logic [LEVEL_W-1:0]      analog_out,
  output logic                    manual_mode
);

  typedef enum logic [1:0] {ph_rx, ph_wait, ph_send} phase_e;
  typedef enum logic [2:0] {ps_idle, ps_cmd, ps_data, ps_digits,
                            ps_term} parse_e;

  function automatic logic is_term(input logic [7:0] b);
    is_term = (b == CH_LF) || (b == CH_CR) || (b == CH_DOLLAR) ||
              (b == CH_STAR) || (b == CH_DOT);
  endfunction

  function automatic logic [7:0] dec_digit(input logic [LEVEL_W-1:0] v,
                                           input int div);
    int q;
    q = (int'(v) / div) % 10;
    dec_digit = CH_ZERO + 8'(q);
  endfunction

  phase_e             ph;
  parse_e             ps;
  logic               rx_meta;
  logic               rx_s;
  logic               rx_prev;
  logic               rx_busy;
  logic [15:0]        rx_cnt;
  logic [3:0]         rx_bit;
  logic [6:0]         rx_shift;
  logic               byte_ok;
  logic [7:0]         rx_byte;
  logic [7:0]         cmd;
  logic [7:0]         reg_id;
  logic [7:0]         ctrl_data;
  logic [LEVEL_W-1:0] num;
  logic               long_term;
  logic [31:0]        wait_cnt;
  logic [2:0]         tx_idx;
  logic               tx_busy;
  logic [15:0]        tx_cnt;
  logic [3:0]         tx_left;
  logic [9:0]         tx_shift;
  logic [3:0]         man_lim;
  logic [3:0]         forced_off;
  logic [3:0]         limit;
  logic [LEVEL_W-1:0] level;

  ////////////////////////////////////////////////////////////////////////
  // Receiver

  // Two-stage synchroniser on the line
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_meta <= 1'b1;
      rx_s    <= 1'b1;
      rx_prev <= 1'b1;
    end else if (ce) begin
      rx_meta <= rx_pin;
      rx_s    <= rx_meta;
      rx_prev <= rx_s;
    end
  end

  // Start only while listening; parity slot skipped
  wire rx_start = !rx_busy && rx_prev && !rx_s && (ph == ph_rx); // RL10
  wire rx_tick  = rx_busy && (rx_cnt == 16'h0000);
  wire rx_last  = rx_tick && (rx_bit == 4'(FRAME_BITS - 1));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_busy  <= 1'b0;
      rx_cnt   <= 16'h0000;
      rx_bit   <= 4'h0;
      rx_shift <= 7'h00;
      byte_ok  <= 1'b0;
      rx_byte  <= 8'h00;
    end else if (ce) begin
      byte_ok <= 1'b0;
      if (rx_start) begin
        rx_busy <= 1'b1;
        rx_cnt  <= 16'(BAUD_DIV / 2);
        rx_bit  <= 4'h0;
      end else if (rx_tick) begin
        rx_cnt <= 16'(BAUD_DIV - 1);
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_s) begin
          rx_busy <= 1'b0;             // False start
        end
        if (rx_bit >= 4'h1 && rx_bit <= 4'(DATA_BITS)) begin
          rx_shift <= {rx_s, rx_shift[6:1]}; // RL18
        end
        if (rx_last) begin
          rx_busy <= 1'b0;
          byte_ok <= rx_s;             // RL19 RL20
          rx_byte <= {1'b0, rx_shift};
        end
      end else if (rx_busy) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command parser and sequencer

  wire       take      = byte_ok && (ph == ph_rx); // RL10
  wire       want_rep  = (cmd == CH_READ) &&
                         ((reg_id == ID_CTRL) || (reg_id == ID_LEVEL));
  wire [31:0] wait_lim = (want_rep && long_term) ? 32'(LONG_WAIT)
                                                 : 32'(SHORT_WAIT);
  wire       wait_done = (ph == ph_wait) && (wait_cnt == wait_lim - 32'h1);
  wire       rep_start = wait_done && want_rep;
  wire       exec      = wait_done && !want_rep;
  wire [15:0] prod     = 16'(num) * 16'h000a + {12'h000, rx_byte[3:0]};
  wire       is_digit  = (rx_byte >= CH_ZERO) && (rx_byte <= 8'h39);
  wire [2:0] rep_len   = (reg_id == ID_CTRL) ? LEN_CTRL : LEN_LEVEL;
  wire       tx_start  = (ph == ph_send) && !tx_busy && (tx_idx < rep_len);
  wire       rep_end   = (ph == ph_send) && !tx_busy && (tx_idx == rep_len);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ph        <= ph_rx;
      ps        <= ps_idle;
      cmd       <= 8'h00;
      reg_id    <= 8'h00;
      ctrl_data <= 8'h00;
      num       <= LEVEL_RST;
      long_term <= 1'b0;
      wait_cnt  <= 32'h0;
      tx_idx    <= 3'h0;
    end else if (ce) begin
      if (take && is_term(rx_byte)) begin
        if (ps == ps_digits || ps == ps_term) begin
          ph        <= ph_wait;                  // RL21
          long_term <= (rx_byte != CH_DOLLAR);   // RL12 RL13
          wait_cnt  <= 32'h0;
        end
        ps <= ps_idle;                           // RL6
      end else if (take) begin
        unique case (ps)
          ps_idle: begin
            if (rx_byte == CH_WRITE || rx_byte == CH_READ ||
                rx_byte == CH_RESET) begin
              cmd <= rx_byte;
              ps  <= ps_cmd;
            end
          end
          ps_cmd: begin
            reg_id <= rx_byte;
            num    <= LEVEL_RST;
            if (cmd == CH_WRITE && rx_byte == ID_CTRL) begin
              ps <= ps_data;
            end else if (cmd == CH_WRITE && rx_byte == ID_LEVEL) begin
              ps <= ps_digits;
            end else begin
              ps <= ps_term;
            end
          end
          ps_data: begin
            ctrl_data <= rx_byte;                // RL6
            ps        <= ps_term;
          end
          ps_digits: begin
            if (is_digit) begin                  // RL8
              num <= (prod > LEVEL_MAX) ? LEVEL_W'(LEVEL_MAX)
                                        : prod[LEVEL_W-1:0];
            end
          end
          ps_term: begin
          end
        endcase
      end
      if (ph == ph_wait) begin
        wait_cnt <= wait_cnt + 32'h1;
      end
      if (rep_start) begin
        ph     <= ph_send;
        tx_idx <= 3'h0;
      end
      if (exec) begin
        ph <= ph_rx;                             // RL15
      end
      if (tx_start) begin
        tx_idx <= tx_idx + 3'h1;
      end
      if (rep_end) begin
        ph <= ph_rx;                             // RL16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output control state

  wire [3:0] reset_one = (exec && cmd == CH_RESET && reg_id >= ID_LIM1 &&
                          reg_id <= ID_LIM4)
                         ? 4'(4'h1 << 2'(reg_id - ID_LIM1)) : 4'h0;
  wire       ctrl_wr   = exec && (cmd == CH_WRITE) && (reg_id == ID_CTRL);
  wire       level_wr  = exec && (cmd == CH_WRITE) && (reg_id == ID_LEVEL);
  wire [3:0] auto_off  = (ctrl_wr && !manual_mode) ? ~ctrl_data[3:0]
                                                   : 4'h0; // RL5
  wire [7:0] ctrl_read = {1'b0, sensor_fail, 1'b0, manual_mode,
                          limit};                  // RL1 RL3 RL4 RL22

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      manual_mode <= 1'b0;
      man_lim     <= LIM_RST;
      forced_off  <= LIM_RST;
      limit       <= LIM_RST;
      level       <= LEVEL_RST;
      analog_out  <= LEVEL_RST;
    end else if (ce) begin
      if (ctrl_wr) begin
        manual_mode <= ctrl_data[CS_MANUAL];              // RL2
        if (ctrl_data[CS_MANUAL]) begin
          man_lim <= ctrl_data[CS_LIM_LSB +: 4];
        end
      end else if (manual_mode) begin
        man_lim <= man_lim & ~reset_one;
      end
      // Set wins over re-arm by the internal source
      forced_off <= (forced_off & limit_auto) | auto_off |
                    (manual_mode ? 4'h0 : reset_one);     // RL5
      limit      <= manual_mode ? man_lim
                                : (limit_auto & ~forced_off); // RL2
      if (level_wr) begin
        level <= num;                                     // RL8
      end
      analog_out <= manual_mode ? level : level_auto;     // RL9
    end
  end

  assign first_limit_output  = limit[0];
  assign second_limit_output = limit[1];
  assign third_limit_output  = limit[2];
  assign fourth_limit_output = limit[3];

  ////////////////////////////////////////////////////////////////////////
  // Transmitter

  wire [7:0] rep_char =
    (reg_id == ID_CTRL) ?
      ((tx_idx == 3'h0) ? ctrl_read : (tx_idx == 3'h1) ? CH_CR : CH_LF) :
      ((tx_idx == 3'h0) ? dec_digit(level, 1000) :
       (tx_idx == 3'h1) ? dec_digit(level, 100) :
       (tx_idx == 3'h2) ? dec_digit(level, 10) :
       (tx_idx == 3'h3) ? dec_digit(level, 1) :
       (tx_idx == 3'h4) ? CH_CR : CH_LF);
  wire par_bit = (parity_sel == PAR_ODD)  ? ~^rep_char[6:0] :
                 (parity_sel == PAR_EVEN) ?  ^rep_char[6:0] : 1'b1; // RL19

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_busy  <= 1'b0;
      tx_cnt   <= 16'h0000;
      tx_left  <= 4'h0;
      tx_shift <= 10'h3ff;
    end else if (ce) begin
      if (tx_start) begin
        tx_busy  <= 1'b1;
        tx_cnt   <= 16'(BAUD_DIV - 1);
        tx_left  <= 4'(FRAME_BITS - 1);                   // RL17
        tx_shift <= {1'b1, par_bit, rep_char[6:0], 1'b0}; // RL18 RL20
      end else if (tx_busy) begin
        if (tx_cnt == 16'h0000) begin
          tx_cnt   <= 16'(BAUD_DIV - 1);
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_left  <= tx_left - 4'h1;
          if (tx_left == 4'h0) begin
            tx_busy <= 1'b0;
          end
        end else begin
          tx_cnt <= tx_cnt - 16'h0001;
        end
      end
    end
  end

  assign tx_pin = tx_busy ? tx_shift[0] : 1'b1;  // RL20
  assign tx_oe  = (ph == ph_send);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys iff ce); endclocking
  default disable iff (!nrst);

  // First character of a control read is being launched
  wire ctrl_first = tx_start && (reg_id == ID_CTRL) && (tx_idx == 3'h0);

  sequence s_wait_end;
    (ph == ph_wait) && want_rep ##1 (ph == ph_send);
  endsequence

  a_reserved_zero: assert property (ctrl_first |=> !tx_shift[6]) // RL3
    else $error("reserved control bit sent as one");
  a_sensor_bit: assert property (ctrl_first |=> // RL4
    tx_shift[CS_SENSOR + 1] == $past(sensor_fail))
    else $error("sensor bit does not follow sensor");
  a_status_bits: assert property ( // RL1
    ctrl_read[3:0] == {fourth_limit_output, third_limit_output,
    second_limit_output, first_limit_output})
    else $error("status bits differ from outputs");
  a_manual_level: assert property ( // RL9
    manual_mode && $past(manual_mode) |-> analog_out == $past(level))
    else $error("analog output not following level in manual");
  a_auto_off_only: assert property ( // RL5
    $past(!manual_mode) |-> (limit & ~$past(limit_auto)) == 4'h0)
    else $error("automatic mode output turned on by write");
  a_busy_ignore: assert property ((ph != ph_rx) && !rx_busy // RL10
    |=> !rx_busy)
    else $error("frame started while not listening");
  a_reply_delay: assert property (s_wait_end |-> // RL12 RL13
    $past(wait_cnt) == (long_term ? 32'(LONG_WAIT - 1)
                                  : 32'(SHORT_WAIT - 1)))
    else $error("reply started at wrong delay");
  a_start_bit: assert property (tx_start |=> !tx_pin) // RL18
    else $error("frame does not begin with start bit");
  a_idle_high: assert property (!tx_busy |-> tx_pin) // RL20
    else $error("line not idle high");
  a_ready_after: assert property (rep_end |=> ph == ph_rx) // RL16
    else $error("not listening after reply");

endmodule
`default_nettype wire

// ---- test/host_link.sv ----
// Host computer model on the meter serial lines
`timescale 1ns/1ps
`default_nettype none
module host_link #(
  parameter int BIT_CYC  = 16,
  parameter int MAX_WAIT = 1000
) (
  // Clock
  input  wire logic clk_sys,
  // Host transmit line, meter receive side
  output logic      rx_line,
  // Meter transmit line
  input  wire logic tx_line
);
  longint cyc;
  longint end_cyc;

  ////////////////////////////////////////////////////////////////////////
  // Free cycle count, used to time replies from the last host frame
  initial cyc = 0;
  initial end_cyc = 0;
  always @(posedge clk_sys) cyc <= cyc + 1;
  // Line idles at mark between frames and after a terminator
  initial rx_line = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // One frame out: start, 7 data LSB first, junk parity, stop
  // Caller keeps to the command spacing and data codes
  task automatic send_char(input logic [7:0] c);
    logic [9:0] fr;
    fr = {1'b1, c[0], c[6:0], 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line = fr[i];
      repeat (BIT_CYC) @(negedge clk_sys);
    end
    end_cyc = cyc;
  endtask

  // One frame in, sampled at mid bit; c is all ones on a timeout
  task automatic recv_char(output logic [7:0] c, output logic p,
                           output logic st, output int lat);
    int n;
    c = 8'hff;
    p = 1'b0;
    st = 1'b0;
    for (n = 0; n < MAX_WAIT && tx_line !== 1'b0; n++) @(negedge clk_sys);
    lat = int'(cyc - end_cyc);
    if (n < MAX_WAIT) begin
      c = 8'h00;
      repeat (BIT_CYC / 2) @(negedge clk_sys);
      for (int i = 0; i < 7; i++) begin
        repeat (BIT_CYC) @(negedge clk_sys);
        c[i] = tx_line;
      end
      repeat (BIT_CYC) @(negedge clk_sys);
      p = tx_line;
      repeat (BIT_CYC) @(negedge clk_sys);
      st = tx_line;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/meter_serial_output_control_tb.sv ----
// Self-checking testbench for the meter serial output control block
`timescale 1ns/1ps
`default_nettype none
module meter_serial_output_control_tb;
  import meter_ctl_pkg::*;
  localparam int BD = 16;
  localparam int SW = 40;
  localparam int LW = 200;
  logic               clk_sys;
  logic               nrst;
  logic               ce;
  logic               rx_pin;
  logic               tx_pin;
  logic               tx_oe;
  logic [1:0]         parity_sel;
  logic [3:0]         limit_auto;
  logic [LEVEL_W-1:0] level_auto;
  logic               sensor_fail;
  logic [3:0]         lims;
  logic [LEVEL_W-1:0] analog_out;
  logic               manual_mode;
  int                 n_errors;
  int                 n_tests;
  int                 k;
  string              terms;

  ////////////////////////////////////////////////////////////////////////
  // Design, host model and clock
  meter_serial_output_control #(
    .BAUD_DIV(BD), .SHORT_WAIT(SW), .LONG_WAIT(LW)
  ) meter_serial_output_control_inst (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .tx_oe(tx_oe), .parity_sel(parity_sel),
    .limit_auto(limit_auto), .level_auto(level_auto),
    .sensor_fail(sensor_fail), .first_limit_output(lims[0]),
    .second_limit_output(lims[1]), .third_limit_output(lims[2]),
    .fourth_limit_output(lims[3]), .analog_out(analog_out),
    .manual_mode(manual_mode));
  host_link #(.BIT_CYC(BD)) host_link_inst (
    .clk_sys(clk_sys), .rx_line(rx_pin), .tx_line(tx_pin));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare, verdict and command tasks
  task automatic chk_val(input string nm, input logic [15:0] exp,
                         input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic par_exp(input logic [7:0] c);
    case (parity_sel)
      PAR_ODD:  return ~^c[6:0];
      PAR_EVEN: return ^c[6:0];
      default:  return 1'b1;
    endcase
  endfunction
  task automatic cmd(input string s);
    foreach (s[i]) host_link_inst.send_char(s[i]);
  endtask
  // Send, then allow the replyless execution window to close
  task automatic run(input string s);
    cmd(s);
    repeat (LW - BD) @(negedge clk_sys);
  endtask
  task automatic rd(input string s, input string exp, input int lo,
                    input int hi);
    logic [7:0] c;
    logic       p;
    logic       st;
    int         lat;
    cmd(s);
    foreach (exp[i]) begin
      host_link_inst.recv_char(c, p, st, lat);
      if (i == 0) chk_rng("reply delay", lo, hi, lat);
      chk_val("reply char", 16'(exp[i]), 16'(c));
      chk_val("parity", 16'(par_exp(c)), 16'(p));
      chk_val("stop", 16'h1, 16'(st));
      chk_val("drive on", 16'h1, 16'(tx_oe));
    end
    repeat (BD) @(negedge clk_sys);
    chk_val("drive off", 16'h0, 16'(tx_oe));
  endtask
  task automatic chk_out(input logic m, input logic [3:0] l,
                         input logic [11:0] a);
    chk_val("manual", 16'(m), 16'(manual_mode));
    chk_val("limits", 16'(l), 16'(lims));
    chk_val("analog", 16'(a), 16'(analog_out));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_errors = 0;
    n_tests = 0;
    nrst = 1'b0;
    ce = 1'b1;
    parity_sel = PAR_ODD;
    limit_auto = 4'h0;
    level_auto = 12'h123;
    sensor_fail = 1'b1;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_out(1'b0, 4'h0, 12'h123);
    // Enable low must freeze the applied level
    ce = 1'b0;
    level_auto = 12'h456;
    repeat (4) @(negedge clk_sys);
    chk_val("frozen analog", 16'h0123, 16'(analog_out));
    ce = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_val("analog follows", 16'h0456, 16'(analog_out));
    level_auto = 12'h123;
    repeat (2) @(negedge clk_sys);
    cmd("VJ5*");
    repeat (BD) @(negedge clk_sys);
    chk_val("early exec", 16'h0, 16'(manual_mode));
    repeat (LW - 2 * BD) @(negedge clk_sys);
    chk_out(1'b1, 4'h5, 12'h000);
    for (k = 0; k < 4; k++) begin
      parity_sel = 2'(k);
      rd("TJ$", "U\r\n", SW - BD, LW);
    end
    terms = "\n\r$.";
    foreach (terms[i]) begin
      run({"VJ", terms.substr(i, i)});
      repeat (2 * BD) @(negedge clk_sys);
      chk_out(1'b1, 4'h5, 12'h000);
    end
    fork
      rd("TJ$", "U\r\n", SW - BD, LW);
      begin
        for (k = 0; k < 4 * LW && tx_oe !== 1'b1; k++) @(negedge clk_sys);
        cmd("RE");
      end
    join
    run("$");
    chk_out(1'b1, 4'h5, 12'h000);
    run("VI2047\n");
    chk_out(1'b1, 4'h5, 12'h7ff);
    run("VI4095\r");
    chk_out(1'b1, 4'h5, 12'hfff);
    rd("TI*", "4095\r\n", LW - BD, 2 * LW);
    run("RE$");
    chk_out(1'b1, 4'h4, 12'hfff);
    limit_auto = 4'hf;
    run("VJ@$");
    chk_out(1'b0, 4'hf, 12'h123);
    run("VJJ.");
    chk_out(1'b0, 4'ha, 12'h123);
    run("VJO$");
    chk_out(1'b0, 4'ha, 12'h123);
    run("RH$");
    chk_out(1'b0, 4'h2, 12'h123);
    run("VI100$");
    chk_out(1'b0, 4'h2, 12'h123);
    sensor_fail = 1'b0;
    run("VJ0$");
    chk_out(1'b1, 4'h0, 12'h064);
    rd("TJ$", "\020\r\n", SW - BD, LW);
    end_sim();
  end

  // Watchdog against a hung run
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
